/* src/pmw_defines.vh */
// Address map constants for the PCI memory window decoder.
// Assumes byte offsets within each window, already stripped of the window base.
`ifndef PMW_DEFINES_VH
`define PMW_DEFINES_VH
`define PMW_U_DATA0_BASE 20'h00000
`define PMW_U_DATA0_LAST 20'h3fffc
`define PMW_U_PRAM0_BASE 20'h40000
`define PMW_U_PRAM0_LAST 20'h4fffc
`define PMW_U_PROM0_BASE 20'h50000
`define PMW_U_PROM0_LAST 20'h53ffc
`define PMW_U_DATA1_BASE 20'h80000
`define PMW_U_DATA1_LAST 20'h9fffc
`define PMW_U_PRAM1_BASE 20'hc0000
`define PMW_U_PRAM1_LAST 20'hcfffc
`define PMW_U_PROM1_BASE 20'hd0000
`define PMW_U_PROM1_LAST 20'hd3ffc
`define PMW_P_DATA0_BASE 20'h00000
`define PMW_P_DATA0_LAST 20'h1fffc
`define PMW_P_PRAM0_BASE 20'h20000
`define PMW_P_PRAM0_LAST 20'h27ffc
`define PMW_P_PROM0_BASE 20'h28000
`define PMW_P_PROM0_LAST 20'h29ffc
`define PMW_P_DATA1_BASE 20'h40000
`define PMW_P_DATA1_LAST 20'h4fffc
`define PMW_P_PRAM1_BASE 20'h60000
`define PMW_P_PRAM1_LAST 20'h67ffc
`define PMW_P_PROM1_BASE 20'h68000
`define PMW_P_PROM1_LAST 20'h69ffc
`define PMW_TGT_NONE 3'h0
`define PMW_TGT_DRAM0 3'h1
`define PMW_TGT_PRAM0 3'h2
`define PMW_TGT_PROM0 3'h3
`define PMW_TGT_DRAM1 3'h4
`define PMW_TGT_PRAM1 3'h5
`define PMW_TGT_PROM1 3'h6
`endif

/* src/pmw_decoder.v */
// PCI memory window decoder: maps unpacked and packed window accesses onto DSP memories.
// Assumes a one-cycle request strobe on mclk and memory read data one cycle after the request.
`timescale 1ns/1ps
`include "pmw_defines.vh"

// Contract
// RULE1 - Unpacked first-core data RAM, four 64K blocks
// RULE2 - Unpacked 16-bit data on lanes 2,1
// RULE3 - Unpacked first-core program RAM and ROM map
// RULE4 - Unpacked second-core data, program RAM, ROM map
// RULE5 - Unpacked reserved holes hold no memory
// RULE6 - Packed window: two halfwords, first-core data RAM
// RULE7 - Packed first-core program RAM and ROM map
// RULE8 - Packed second-core data, program RAM, ROM map
// RULE9 - Packed reserved holes hold no memory
// RULE10 - Packed program access moves upper 16 bits
// RULE11 - Accept only with memory space enable set
// RULE12 - Reserved/unused read zero; ROM, reserved writes ignored
// RULE13 - Master uses aligned addresses, ignores reserved
module pmw_decoder
(
   mclk,
   rst_n,
   req_valid,
   req_packed,
   req_write,
   req_addr,
   req_be,
   req_wdata,
   mem_space_en,
   rsp_valid,
   rsp_rdata,
   mem_req,
   mem_we,
   mem_target,
   mem_addr,
   mem_wmask,
   mem_wdata,
   mem_rdata
);
input wire mclk;
input wire rst_n;
input wire req_valid;
input wire req_packed;
input wire req_write;
input wire [19:0] req_addr;
input wire [3:0] req_be;
input wire [31:0] req_wdata;
input wire mem_space_en;
output wire rsp_valid;
output reg [31:0] rsp_rdata;
output reg [1:0] mem_req;
output reg mem_we;
output reg [2:0] mem_target;
output reg [15:0] mem_addr;
output reg [47:0] mem_wmask;
output reg [47:0] mem_wdata;
input wire [47:0] mem_rdata;

reg [2:0] tgt;
reg [19:0] base;
reg is_prog;
reg is_rom;
reg [15:0] waddr;
reg [1:0] lane_req;
reg [47:0] wmask_c;
reg [47:0] wdata_c;
reg rd_pend_reg;
reg packed_reg;
reg prog_reg;
reg [1:0] lanes_reg;
reg [31:0] rdata_c;
wire [19:0] off;
wire take;

assign off = req_addr - base;
assign take = req_valid & mem_space_en; // [RULE11]
assign rsp_valid = rd_pend_reg;

// Region decode for both footprints.
always @*
begin
   tgt = `PMW_TGT_NONE; // [RULE5] [RULE9]
   base = 20'h00000;
   if (!req_packed)
   begin
      if (req_addr <= `PMW_U_DATA0_LAST)
      begin
         tgt = `PMW_TGT_DRAM0; // [RULE1]
         base = `PMW_U_DATA0_BASE;
      end
      else if (req_addr >= `PMW_U_PRAM0_BASE && req_addr <= `PMW_U_PRAM0_LAST)
      begin
         tgt = `PMW_TGT_PRAM0; // [RULE3]
         base = `PMW_U_PRAM0_BASE;
      end
      else if (req_addr >= `PMW_U_PROM0_BASE && req_addr <= `PMW_U_PROM0_LAST)
      begin
         tgt = `PMW_TGT_PROM0; // [RULE3]
         base = `PMW_U_PROM0_BASE;
      end
      else if (req_addr >= `PMW_U_DATA1_BASE && req_addr <= `PMW_U_DATA1_LAST)
      begin
         tgt = `PMW_TGT_DRAM1; // [RULE4]
         base = `PMW_U_DATA1_BASE;
      end
      else if (req_addr >= `PMW_U_PRAM1_BASE && req_addr <= `PMW_U_PRAM1_LAST)
      begin
         tgt = `PMW_TGT_PRAM1; // [RULE4]
         base = `PMW_U_PRAM1_BASE;
      end
      else if (req_addr >= `PMW_U_PROM1_BASE && req_addr <= `PMW_U_PROM1_LAST)
      begin
         tgt = `PMW_TGT_PROM1; // [RULE4]
         base = `PMW_U_PROM1_BASE;
      end
   end
   else
   begin
      if (req_addr <= `PMW_P_DATA0_LAST)
      begin
         tgt = `PMW_TGT_DRAM0; // [RULE6]
         base = `PMW_P_DATA0_BASE;
      end
      else if (req_addr >= `PMW_P_PRAM0_BASE && req_addr <= `PMW_P_PRAM0_LAST)
      begin
         tgt = `PMW_TGT_PRAM0; // [RULE7]
         base = `PMW_P_PRAM0_BASE;
      end
      else if (req_addr >= `PMW_P_PROM0_BASE && req_addr <= `PMW_P_PROM0_LAST)
      begin
         tgt = `PMW_TGT_PROM0; // [RULE7]
         base = `PMW_P_PROM0_BASE;
      end
      else if (req_addr >= `PMW_P_DATA1_BASE && req_addr <= `PMW_P_DATA1_LAST)
      begin
         tgt = `PMW_TGT_DRAM1; // [RULE8]
         base = `PMW_P_DATA1_BASE;
      end
      else if (req_addr >= `PMW_P_PRAM1_BASE && req_addr <= `PMW_P_PRAM1_LAST)
      begin
         tgt = `PMW_TGT_PRAM1; // [RULE8]
         base = `PMW_P_PRAM1_BASE;
      end
      else if (req_addr >= `PMW_P_PROM1_BASE && req_addr <= `PMW_P_PROM1_LAST)
      begin
         tgt = `PMW_TGT_PROM1; // [RULE8]
         base = `PMW_P_PROM1_BASE;
      end
   end
end

// Word addressing, lane requests and write steering.
always @*
begin
   is_prog = (tgt == `PMW_TGT_PRAM0) || (tgt == `PMW_TGT_PROM0) ||
             (tgt == `PMW_TGT_PRAM1) || (tgt == `PMW_TGT_PROM1);
   is_rom = (tgt == `PMW_TGT_PROM0) || (tgt == `PMW_TGT_PROM1);
   wmask_c = 48'h000000000000;
   wdata_c = 48'h000000000000;
   if (req_packed)
   begin
      waddr = {off[16:2], 1'b0}; // [RULE6]
      lane_req = {|req_be[3:2], |req_be[1:0]};
      if (is_prog)
      begin
         wdata_c = {req_wdata[31:16], 8'h00, req_wdata[15:0], 8'h00}; // [RULE10]
         wmask_c = {{8{req_be[3]}}, {8{req_be[2]}}, 8'h00, {8{req_be[1]}}, {8{req_be[0]}}, 8'h00};
      end
      else
      begin
         wdata_c = {8'h00, req_wdata[31:16], 8'h00, req_wdata[15:0]};
         wmask_c = {8'h00, {8{req_be[3]}}, {8{req_be[2]}}, 8'h00, {8{req_be[1]}}, {8{req_be[0]}}};
      end
   end
   else
   begin
      waddr = off[17:2]; // [RULE1]
      lane_req = 2'b01;
      if (is_prog)
      begin
         wdata_c = {24'h000000, req_wdata[23:0]}; // [RULE3]
         wmask_c = {24'h000000, {8{req_be[2]}}, {8{req_be[1]}}, {8{req_be[0]}}};
      end
      else
      begin
         wdata_c = {32'h00000000, req_wdata[23:8]}; // [RULE2]
         wmask_c = {32'h00000000, {8{req_be[2]}}, {8{req_be[1]}}};
      end
   end
end

// Read data steering back onto the PCI lanes.
always @*
begin
   rdata_c = 32'h00000000; // [RULE12]
   // Reserved space in either footprint returns zero, never the idle memory bus.
   if (lanes_reg[0]) // [RULE5] [RULE9]
   begin
      if (packed_reg)
      begin
         if (prog_reg)
            rdata_c = {mem_rdata[47:32], mem_rdata[23:8]}; // [RULE10]
         else
            rdata_c = {mem_rdata[39:24], mem_rdata[15:0]};
      end
      else if (prog_reg)
         rdata_c = {8'h00, mem_rdata[23:0]};
      else
         rdata_c = {8'h00, mem_rdata[15:0], 8'h00}; // [RULE2]
   end
end

always @(posedge mclk or negedge rst_n)
begin
   if (!rst_n)
   begin
      mem_req <= 2'b00;
      mem_we <= 1'b0;
      mem_target <= 3'h0;
      mem_addr <= 16'h0000;
      mem_wmask <= 48'h000000000000;
      mem_wdata <= 48'h000000000000;
      rd_pend_reg <= 1'b0;
      packed_reg <= 1'b0;
      prog_reg <= 1'b0;
      lanes_reg <= 2'b00;
      rsp_rdata <= 32'h00000000;
   end
   else
   begin
      // Reserved space and ROM writes never reach memory.
      if (take && tgt != `PMW_TGT_NONE && !(req_write && is_rom)) // [RULE12] [RULE11]
         mem_req <= lane_req;
      else
         mem_req <= 2'b00;
      mem_we <= take && req_write && tgt != `PMW_TGT_NONE && !is_rom; // [RULE12]
      mem_target <= tgt;
      mem_addr <= waddr;
      mem_wmask <= wmask_c;
      mem_wdata <= wdata_c;
      rd_pend_reg <= take & ~req_write;
      packed_reg <= req_packed;
      prog_reg <= is_prog;
      lanes_reg <= (tgt == `PMW_TGT_NONE) ? 2'b00 : 2'b11;
      if (rd_pend_reg)
         rsp_rdata <= rdata_c;
   end
end
endmodule // pmw_decoder

/* dv/pmw_monitor.sv */
// Port checker for the window decoder.
// Bound onto pmw_decoder by the bench.
`timescale 1ns/1ps
module pmw_monitor
(
   input wire mclk, rst_n, req_valid, req_packed, req_write, mem_space_en, rsp_valid,
   input wire [19:0] req_addr,
   input wire [31:0] rsp_rdata,
   input wire [1:0] mem_req,
   input wire [2:0] mem_target,
   input wire [15:0] mem_addr,
   input wire [47:0] mem_rdata
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire [19:0] a = req_addr;
   wire tk = req_valid & mem_space_en;
   wire u = tk & !req_write & !req_packed;
   wire p = tk & !req_write & req_packed;
   a_off_quiet: assert property (req_valid & !mem_space_en |=> !mem_req && !rsp_valid)
      else $error("off");
   a_rom_safe: assert property (tk & req_write & !req_packed & a[19:14] == 6'h14 |=> !mem_req)
      else $error("rom");
   a_udata_lanes: assert property (u & a < 20'h40000 |=> mem_addr == $past(a[17:2])
      ##1 rsp_rdata == {8'h0, $past(mem_rdata[15:0]), 8'h0}) else $error("udata");
   a_uprog_lanes: assert property (u & a[19:16] == 4'h4 |=> mem_target == 3'h2
      ##1 rsp_rdata == {8'h0, $past(mem_rdata[23:0])}) else $error("uprog");
   a_ures_zero: assert property (u & a[19:17] == 3'h5 |=> !mem_req ##1 rsp_rdata == 32'h0)
      else $error("ures");
   a_pdata_pair: assert property (p & a < 20'h20000 |=> mem_req == 2'h3 && mem_addr == {$past(a[16:2]), 1'h0}
      ##1 rsp_rdata == {$past(mem_rdata[39:24]), $past(mem_rdata[15:0])}) else $error("pdata");
   a_pprog_upper: assert property (p & a[19:15] == 5'h4 |=> mem_target == 3'h2
      ##1 rsp_rdata == {$past(mem_rdata[47:32]), $past(mem_rdata[23:8])}) else $error("pprog");
   a_pres_zero: assert property (p & a[19:16] == 4'h5 |=> !mem_req ##1 rsp_rdata == 32'h0)
      else $error("pres");
   c_packed: cover property (p);
   c_write: cover property (tk & req_write);
   c_off: cover property (req_valid & !mem_space_en);
endmodule // pmw_monitor

/* dv/pmw_mem_model.sv */
// Memory model behind the DSP memory port.
// Read data shows only in the strobe cycle.
`timescale 1ns/1ps
module pmw_mem_model
(
   input wire mclk, mem_we,
   input wire [1:0] mem_req,
   input wire [2:0] mem_target,
   input wire [15:0] mem_addr,
   input wire [47:0] mem_wmask, mem_wdata,
   output logic [47:0] mem_rdata
);
   logic [23:0] m [0:524287];
   logic [5:0] cnt = 6'h0;
   wire [18:0] k = {mem_target, mem_addr};
   wire [18:0] k1 = k + 19'h1;
   // Every location starts out holding its own index, so reads are predictable.
   initial
      for (int i = 0; i < 524288; i++)
         m[i] = {5'h0, 19'(i)};
   always_comb
      mem_rdata = (mem_req != 2'h0 && !mem_we) ? {m[k1], m[k]} : {8{cnt}};
   always @(posedge mclk)
   begin
      cnt <= cnt + 6'h1;
      if (mem_we & mem_req[0])
         m[k] <= m[k] & ~mem_wmask[23:0] | mem_wdata[23:0] & mem_wmask[23:0];
      if (mem_we & mem_req[1])
         m[k1] <= m[k1] & ~mem_wmask[47:24] | mem_wdata[47:24] & mem_wmask[47:24];
   end
endmodule // pmw_mem_model

/* dv/pmw_decoder_bench.sv */
// Bench for the window decoder.
// Needs the memory model and the checker.
`timescale 1ns/1ps
module pmw_decoder_bench;
   localparam logic U = 1'h0, P = 1'h1, W = 1'h1;
   logic mclk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_packed = 1'h0, req_write = 1'h0, mem_space_en = 1'h1;
   logic [19:0] req_addr = 20'h0;
   logic [3:0] req_be = 4'hf;
   logic [31:0] req_wdata = 32'h0;
   wire rsp_valid, mem_we;
   wire [31:0] rsp_rdata;
   wire [1:0] mem_req;
   wire [2:0] mem_target;
   wire [15:0] mem_addr;
   wire [47:0] mem_wmask, mem_wdata, mem_rdata;
   int num_errors = 0, check_count = 0;
   pmw_decoder i_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_packed(req_packed),
      .req_write(req_write), .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata),
      .mem_space_en(mem_space_en), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_req(mem_req),
      .mem_we(mem_we), .mem_target(mem_target), .mem_addr(mem_addr), .mem_wmask(mem_wmask),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   pmw_mem_model i_mem (.mclk(mclk), .mem_we(mem_we), .mem_req(mem_req), .mem_target(mem_target),
      .mem_addr(mem_addr), .mem_wmask(mem_wmask), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   initial forever #4 mclk = ~mclk;
   task automatic chk(input logic [31:0] s, e, input string n);
      check_count++;
      if (s !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic go(input logic p, w, input logic [19:0] a, input logic [31:0] d);
      @(negedge mclk);
      {req_valid, req_packed, req_write, req_addr, req_wdata} = {1'h1, p, w, a, d};
      @(negedge mclk);
      req_valid = 1'h0;
   endtask
   task automatic rd(input logic p, input logic [19:0] a, input logic [31:0] e);
      go(p, 1'h0, a, 32'h0);
      chk({31'h0, rsp_valid}, {31'h0, mem_space_en}, "rsp_valid");
      repeat (2) @(negedge mclk);
      chk(rsp_rdata, e, "rsp_rdata");
   endtask
   task t_unpacked;
      go(U, W, 20'h3fffc, 32'hffabcdff);
      rd(U, 20'h3fffc, 32'h00abcd00);
      go(U, W, 20'h53ffc, 32'h0);
      rd(U, 20'h53ffc, 32'h00030fff);
      rd(U, 20'ha0000, 32'h0);
   endtask
   task t_packed;
      go(P, W, 20'h20000, 32'h99998888);
      rd(U, 20'h40000, 32'h00888800);
      rd(U, 20'h40004, 32'h00999901);
      rd(P, 20'h2a000, 32'h0);
      rd(P, 20'h1fffc, 32'habcdfffe);
      rd(P, 20'h50000, 32'h0);
   endtask
   task t_second;
      rd(P, 20'h60000, 32'h05000500);
      rd(U, 20'h54000, 32'h0);
      rd(P, 20'h48000, 32'h40014000);
      rd(P, 20'h6a000, 32'h0);
      rd(U, 20'h90000, 32'h00400000);
      rd(U, 20'hc0004, 32'h00050001);
      rd(U, 20'hd3ffc, 32'h00060fff);
      rd(U, 20'hd4000, 32'h0);
   endtask
   task t_enable;
      mem_space_en = 1'h0;
      go(U, W, 20'h4, 32'h00ffff00);
      mem_space_en = 1'h1;
      rd(U, 20'h4, 32'h00000100);
      mem_space_en = 1'h0;
      rd(U, 20'h8, 32'h00000100);
      mem_space_en = 1'h1;
   endtask
   task summarize;
      if (num_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(negedge mclk);
      rst_n = 1'h1;
      t_unpacked();
      t_packed();
      t_second();
      t_enable();
      summarize();
   end
   initial
   begin
      #5000;
      num_errors++;
      summarize();
   end
endmodule // pmw_decoder_bench
bind pmw_decoder pmw_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_packed(req_packed),
   .req_write(req_write), .mem_space_en(mem_space_en), .rsp_valid(rsp_valid), .req_addr(req_addr),
   .rsp_rdata(rsp_rdata), .mem_req(mem_req), .mem_target(mem_target), .mem_addr(mem_addr),
   .mem_rdata(mem_rdata));
